/* hw/amp_pkg.sv */
/*
 Shared constants for the address map and privilege unit.
 Assumes a single 200 MHz processor clock and synchronous reset.
*/
package amp_pkg;
  // ==========================================================
  // Widths
  localparam int LOG_W   = 16;
  localparam int PHYS_W  = 20;
  localparam int LIM_W   = 11;
  localparam int BIAS_W  = 16;
  localparam int BIAS_SH = 5;
  localparam int NFILES  = 3;
  localparam int NSEG    = 3;
  // ==========================================================
  // Status bit positions and reset values
  localparam int           PRIV_BIT   = 7;
  localparam int           MAPSEL_BIT = 8;
  localparam logic [1:0]   FILE_RST   = 2'h0;
  localparam logic         USER_RST   = 1'h0;
  localparam logic [10:0]  LIM_RST    = 11'h000;
  localparam logic [15:0]  BIAS_RST   = 16'h0000;
  // Word index inside a map file load: limits 0..2, biases 3..5
  localparam logic [2:0]   IDX_BIAS0  = 3'h3;
  localparam logic [2:0]   IDX_LAST   = 3'h5;
  // Result of the limit compare
  typedef enum logic [1:0] {
    AMP_SEG1 = 2'b00,
    AMP_SEG2 = 2'b01,
    AMP_SEG3 = 2'b11,
    AMP_FAULT = 2'b10
  } amp_seg_t;
endpackage

/* hw/amp_map_mem.sv */
/*
 Map file storage: one limit table and one bias table per segment,
 indexed by map file, read data registered.
 Assumes the caller only writes during a privileged load.
*/
`timescale 1ns/1ps
module amp_map_mem (
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  input  wire logic                       wrEn,
  input  wire logic [1:0]                 wrFile,
  input  wire logic [2:0]                 wrIdx,
  input  wire logic [15:0]                wrData,
  input  wire logic [1:0]                 rdFile,
  output logic [3*amp_pkg::LIM_W-1:0]     limOut,
  output logic [3*amp_pkg::BIAS_W-1:0]    biasOut
);
  // ==========================================================
  // Storage
  logic [amp_pkg::LIM_W-1:0]  limQ  [amp_pkg::NFILES][amp_pkg::NSEG];
  logic [amp_pkg::BIAS_W-1:0] biasQ [amp_pkg::NFILES][amp_pkg::NSEG];

  for (genvar f = 0; f < amp_pkg::NFILES; f++) begin : g_f
    for (genvar s = 0; s < amp_pkg::NSEG; s++) begin : g_s
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          limQ[f][s]  <= amp_pkg::LIM_RST;
          biasQ[f][s] <= amp_pkg::BIAS_RST;
        end else if (wrEn && wrFile == 2'(f)) begin
          if (wrIdx == 3'(s))
            limQ[f][s] <= wrData[amp_pkg::LIM_W-1:0];
          if (wrIdx == 3'(s) + amp_pkg::IDX_BIAS0)
            biasQ[f][s] <= wrData;
        end
      end
    end
  end

  // ==========================================================
  // Registered read port; one process so each output has one driver
  logic [3*amp_pkg::LIM_W-1:0]  limRdD;
  logic [3*amp_pkg::BIAS_W-1:0] biasRdD;
  always_comb begin
    limRdD  = '0;
    biasRdD = '0;
    for (int s = 0; s < amp_pkg::NSEG; s++) begin
      // File 3 does not exist and reads as zero
      if (rdFile < 2'(amp_pkg::NFILES)) begin
        limRdD[s*amp_pkg::LIM_W +: amp_pkg::LIM_W]    = limQ[rdFile][s];
        biasRdD[s*amp_pkg::BIAS_W +: amp_pkg::BIAS_W] = biasQ[rdFile][s];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      limOut  <= '0;
      biasOut <= '0;
    end else begin
      limOut  <= limRdD;
      biasOut <= biasRdD;
    end
  end
endmodule

/* hw/amp_map_priv.sv */
/*
 Address map and privilege unit: limit compare, bias add, mapping
 fault, privilege check and the privilege / map file state.
 Assumes the core holds logAddr and memReq steady for two cycles
 per access and drives one-cycle event pulses.
*/
// How it works
// - Three map files, three limits, three biases
// - Mapping reaches memory beyond 32K words
// - Physical address is logical plus bias shifted five
// - Byte select bit ignored when mapping
// - Limits stored complemented; compare uncomplements
// - At or below limit one uses bias one
// - Between limit one and two uses bias two
// - Between limit two and three uses bias three
// - Above limit three: fault, no access
// - Privileged op in user mode: error, no execute
// - Reset, interrupt, extended op: privileged, file 0
// - Status bit 7 set means user mode
// - Status bit 8 picks map file 0 or 1
`timescale 1ns/1ps
module amp_map_priv (
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic [15:0]   logAddr,
  input  wire logic          memReq,
  input  wire logic          privOp,
  input  wire logic          loadMapReq,
  input  wire logic [1:0]    loadFile,
  input  wire logic [2:0]    loadIdx,
  input  wire logic [15:0]   loadData,
  input  wire logic          statusWr,
  input  wire logic [15:0]   statusIn,
  input  wire logic          intTaken,
  input  wire logic          xopTaken,
  output logic [19:0]        physAddr,
  output logic               physReq,
  output logic               mapFault,
  output logic               privFault,
  output logic               privOpGo,
  output logic               userMode,
  output logic               mapFileSel
);
  // ==========================================================
  // Privilege and map file state
  logic userQ, userD, fileQ, fileD;
  logic entryEvt;
  always_comb begin
    entryEvt = intTaken || xopTaken;
    userD = userQ;
    fileD = fileQ;
    if (entryEvt) begin
      userD = amp_pkg::USER_RST;
      fileD = 1'b0;
    end else if (statusWr && !userQ) begin
      userD = statusIn[amp_pkg::PRIV_BIT];
      fileD = statusIn[amp_pkg::MAPSEL_BIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      userQ <= amp_pkg::USER_RST;
      fileQ <= 1'b0;
    end else begin
      userQ <= userD;
      fileQ <= fileD;
    end
  end

  // ==========================================================
  // Map storage; load gated by privilege
  logic wrEn;
  logic [3*amp_pkg::LIM_W-1:0]  limAll;
  logic [3*amp_pkg::BIAS_W-1:0] biasAll;
  assign wrEn = loadMapReq && !userQ && loadIdx <= amp_pkg::IDX_LAST;
  amp_map_mem u_mem (
    .clk_sys (clk_sys),
    .srst    (srst),
    .wrEn    (wrEn),
    .wrFile  (loadFile),
    .wrIdx   (loadIdx),
    .wrData  (loadData),
    .rdFile  ({1'b0, fileQ}),
    .limOut  (limAll),
    .biasOut (biasAll)
  );

  // ==========================================================
  // Segment select
  function automatic amp_pkg::amp_seg_t segOf(
    input logic [10:0] page,
    input logic [32:0] lims);
    logic [10:0] l1, l2, l3;
    l1 = ~lims[10:0];
    l2 = ~lims[21:11];
    l3 = ~lims[32:22];
    if (page <= l1)      segOf = amp_pkg::AMP_SEG1;
    else if (page <= l2) segOf = amp_pkg::AMP_SEG2;
    else if (page <= l3) segOf = amp_pkg::AMP_SEG3;
    else                 segOf = amp_pkg::AMP_FAULT;
  endfunction

  logic [19:0] physD;
  logic        physReqD, mapFaultD, privFaultD, privGoD;
  logic [15:0] biasSel;
  amp_pkg::amp_seg_t seg;
  always_comb begin
    seg = segOf(logAddr[15:5], limAll);
    case (seg)
      amp_pkg::AMP_SEG1: biasSel = biasAll[15:0];
      amp_pkg::AMP_SEG2: biasSel = biasAll[31:16];
      amp_pkg::AMP_SEG3: biasSel = biasAll[47:32];
      default:           biasSel = 16'h0000;
    endcase
    // Bias widens the reach past 32K words; its top bit
    // falls off the 20-bit bus, so software keeps it clear
    physD = {4'h0, logAddr[15:1], 1'b0} +
            {biasSel[14:0], 5'h00};
    physReqD   = memReq && seg != amp_pkg::AMP_FAULT;
    mapFaultD  = memReq && seg == amp_pkg::AMP_FAULT;
    privFaultD = privOp && userQ;
    privGoD    = privOp && !userQ;
  end

  // ==========================================================
  // Output registers; the map read adds one cycle of latency
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      physAddr   <= 20'h00000;
      physReq    <= 1'b0;
      mapFault   <= 1'b0;
      privFault  <= 1'b0;
      privOpGo   <= 1'b0;
      userMode   <= amp_pkg::USER_RST;
      mapFileSel <= 1'b0;
    end else begin
      physAddr   <= physD;
      physReq    <= physReqD;
      mapFault   <= mapFaultD;
      privFault  <= privFaultD;
      privOpGo   <= privGoD;
      userMode   <= userD;
      mapFileSel <= fileD;
    end
  end

  // ==========================================================
  // Checks
  property p_fault_no_req;
    @(posedge clk_sys) disable iff (srst)
      mapFault |-> !physReq;
  endproperty
  a_fault_no_req: assert property (p_fault_no_req)
    else $error("fault with access");

  property p_priv_block;
    @(posedge clk_sys) disable iff (srst)
      privOp && userQ |=> privFault && !privOpGo;
  endproperty
  a_priv_block: assert property (p_priv_block)
    else $error("privileged op ran in user mode");

  property p_entry;
    @(posedge clk_sys) disable iff (srst)
      entryEvt |=> !userMode && !mapFileSel;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry did not force privileged file 0");

  property p_user_hold;
    @(posedge clk_sys) disable iff (srst)
      userQ && !entryEvt |=> userQ;
  endproperty
  a_user_hold: assert property (p_user_hold)
    else $error("user mode left without entry");

  property p_lsb;
    @(posedge clk_sys) disable iff (srst)
      physReq |-> physAddr[0] == 1'b0;
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("byte bit leaked");

  property p_seg1;
    @(posedge clk_sys) disable iff (srst)
      memReq && seg == amp_pkg::AMP_SEG1 |=>
        physAddr == {4'h0, $past(logAddr[15:1]), 1'b0} +
                    {$past(biasAll[14:0]), 5'h00};
  endproperty
  a_seg1: assert property (p_seg1)
    else $error("bias one sum wrong");

  property p_seg2;
    @(posedge clk_sys) disable iff (srst)
      memReq && seg == amp_pkg::AMP_SEG2 |=>
        physAddr == {4'h0, $past(logAddr[15:1]), 1'b0} +
                    {$past(biasAll[30:16]), 5'h00};
  endproperty
  a_seg2: assert property (p_seg2)
    else $error("bias two not used");

  property p_fault_cause;
    @(posedge clk_sys) disable iff (srst)
      mapFault |-> $past(logAddr[15:5]) > ~$past(limAll[32:22]);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault below limit three");

  // ==========================================================
  // Sequences for the multi-step checks
  sequence s_entry;
    entryEvt;
  endsequence
  sequence s_priv_file0;
    !userMode && !mapFileSel;
  endsequence
  sequence s_ok_req;
    memReq && seg != amp_pkg::AMP_FAULT;
  endsequence
  sequence s_granted;
    physReq && !mapFault;
  endsequence
  sequence s_bad_req;
    memReq && seg == amp_pkg::AMP_FAULT;
  endsequence
  sequence s_refused;
    mapFault && !physReq;
  endsequence
  sequence s_status_wr;
    statusWr && !userQ && !entryEvt;
  endsequence
  sequence s_in_reset;
    srst;
  endsequence

  property p_entry_hold;
    @(posedge clk_sys) disable iff (srst)
      s_entry ##1 !statusWr |=> s_priv_file0;
  endproperty
  a_entry_hold: assert property (p_entry_hold)
    else $error("privileged file 0 not kept after entry");

  property p_grant;
    @(posedge clk_sys) disable iff (srst)
      s_ok_req |=> s_granted;
  endproperty
  a_grant: assert property (p_grant)
    else $error("in-range access not granted");

  property p_refuse;
    @(posedge clk_sys) disable iff (srst)
      s_bad_req |=> s_refused;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("out-of-range access not refused");

  property p_status;
    @(posedge clk_sys) disable iff (srst)
      s_status_wr |=> userMode == $past(statusIn[amp_pkg::PRIV_BIT]);
  endproperty
  a_status: assert property (p_status)
    else $error("user bit not taken from status");

  property p_file;
    @(posedge clk_sys) disable iff (srst)
      s_status_wr |=> mapFileSel == $past(statusIn[amp_pkg::MAPSEL_BIT]);
  endproperty
  a_file: assert property (p_file)
    else $error("map file bit not taken from status");

  property p_priv_go;
    @(posedge clk_sys) disable iff (srst)
      privOp && !userQ |=> privOpGo && !privFault;
  endproperty
  a_priv_go: assert property (p_priv_go)
    else $error("privileged op blocked in privileged mode");

  property p_reset;
    @(posedge clk_sys)
      s_in_reset |=> s_priv_file0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not force privileged file 0");

  property p_seg3;
    @(posedge clk_sys) disable iff (srst)
      memReq && seg == amp_pkg::AMP_SEG3 |=>
        physAddr == {4'h0, $past(logAddr[15:1]), 1'b0} +
                    {$past(biasAll[46:32]), 5'h00};
  endproperty
  a_seg3: assert property (p_seg3)
    else $error("bias three sum wrong");

  property p_ok_below;
    @(posedge clk_sys) disable iff (srst)
      physReq |-> $past(logAddr[15:5]) <= ~$past(limAll[32:22]);
  endproperty
  a_ok_below: assert property (p_ok_below)
    else $error("access granted above limit three");
endmodule

/* sim/amp_mem_side.sv */
/*
 Memory side model: logs mapped accesses.
 Assumes physReq is high one cycle per granted access cycle.
*/
`timescale 1ns/1ps
module amp_mem_side (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [19:0] physAddr,
  input  wire logic        physReq,
  output logic      [15:0] accCount,
  output logic      [19:0] lastAddr
);
  // ==========================================
  // Access log
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      accCount <= 16'h0000;
      lastAddr <= 20'h00000;
    end else if (physReq) begin
      accCount <= accCount + 16'h0001;
      lastAddr <= physAddr;
    end
  end
endmodule

/* sim/tb.sv */
/*
 Testbench for the map and privilege unit.
 Assumes inputs change at falling edges, 200 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  logic        clk_sys, srst, memReq, privOp, loadMapReq;
  logic        statusWr, intTaken, xopTaken;
  logic [15:0] logAddr, loadData, statusIn, accCount;
  logic [1:0]  loadFile;
  logic [2:0]  loadIdx;
  logic [19:0] physAddr, lastAddr;
  logic        physReq, mapFault, privFault, privOpGo, userMode, mapFileSel;
  int          err_total, n_compared, cyc;
  // Worked map: limits stored complemented, then biases
  logic [15:0] w [6] = '{16'h0778, 16'h02f8, 16'h0040,
                         16'h0000, 16'h188f, 16'h2000};
  logic [15:0] ad [5] = '{16'h10ff, 16'h1100, 16'ha0ff, 16'ha100, 16'hf7ff};
  int          bi [5] = '{0, 1, 1, 2, 2};

  amp_map_priv i_dut (.clk_sys(clk_sys), .srst(srst), .logAddr(logAddr),
    .memReq(memReq), .privOp(privOp), .loadMapReq(loadMapReq),
    .loadFile(loadFile), .loadIdx(loadIdx), .loadData(loadData),
    .statusWr(statusWr), .statusIn(statusIn), .intTaken(intTaken),
    .xopTaken(xopTaken), .physAddr(physAddr), .physReq(physReq),
    .mapFault(mapFault), .privFault(privFault), .privOpGo(privOpGo),
    .userMode(userMode), .mapFileSel(mapFileSel));
  amp_mem_side i_mem (.clk_sys(clk_sys), .srst(srst), .physAddr(physAddr),
    .physReq(physReq), .accCount(accCount), .lastAddr(lastAddr));

  // ==========================================
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [19:0] mapped(logic [15:0] a, logic [15:0] b);
    return {4'h0, a[15:1], 1'b0} + {b[14:0], 5'h00};
  endfunction
  task automatic chkA(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkF(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ld(input logic [1:0] f, input int i, input logic [15:0] d);
    @(negedge clk_sys);
    loadMapReq = 1'b1;
    loadFile = f;
    loadIdx = i[2:0];
    loadData = d;
    @(negedge clk_sys);
    loadMapReq = 1'b0;
  endtask
  // Settle two cycles: table read is registered
  task automatic st(input logic [15:0] v);
    @(negedge clk_sys);
    statusWr = 1'b1;
    statusIn = v;
    @(negedge clk_sys);
    statusWr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic acc(input logic [15:0] a, input logic [19:0] e,
                     input logic f);
    @(negedge clk_sys);
    memReq = 1'b1;
    logAddr = a;
    repeat (2) @(negedge clk_sys);
    if (!f) chkA(physAddr, e);
    chkF(physReq, !f);
    chkF(mapFault, f);
    memReq = 1'b0;
  endtask
  task automatic pr(input logic go);
    @(negedge clk_sys);
    privOp = 1'b1;
    @(negedge clk_sys);
    chkF(privOpGo, go);
    chkF(privFault, !go);
    privOp = 1'b0;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_map;
    logic [15:0] c;
    for (int i = 0; i < 6; i++) ld(2'h0, i, w[i]);
    repeat (2) @(negedge clk_sys);
    for (int k = 0; k < 5; k++)
      acc(ad[k], mapped(ad[k], w[3+bi[k]]), 1'b0);
    // Let the last granted cycle reach the access log first
    @(negedge clk_sys);
    c = accCount;
    chkA(lastAddr, mapped(ad[4], w[5]));
    acc(16'hf800, 20'h00000, 1'b1);
    @(negedge clk_sys);
    chkA({4'h0, accCount}, {4'h0, c});
    chkA(lastAddr, mapped(ad[4], w[5]));
    $display("t_map done");
  endtask
  task automatic t_file;
    ld(2'h1, 0, 16'h0000);
    ld(2'h1, 3, 16'h1000);
    st(16'h0100);
    chkF(mapFileSel, 1'b1);
    acc(16'h0005, mapped(16'h0005, 16'h1000), 1'b0);
    $display("t_file done");
  endtask
  task automatic t_priv;
    pr(1'b1);
    st(16'h0180);
    chkF(userMode, 1'b1);
    pr(1'b0);
    ld(2'h1, 3, 16'h3000);
    repeat (2) @(negedge clk_sys);
    acc(16'h0005, mapped(16'h0005, 16'h1000), 1'b0);
    intTaken = 1'b1;
    @(negedge clk_sys);
    intTaken = 1'b0;
    chkF(userMode, 1'b0);
    chkF(mapFileSel, 1'b0);
    st(16'h0180);
    chkF(userMode, 1'b1);
    xopTaken = 1'b1;
    @(negedge clk_sys);
    xopTaken = 1'b0;
    chkF(userMode, 1'b0);
    chkF(mapFileSel, 1'b0);
    st(16'h0180);
    st(16'h0000);
    chkF(userMode, 1'b1);
    chkF(mapFileSel, 1'b1);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    chkF(userMode, 1'b0);
    chkF(mapFileSel, 1'b0);
    @(negedge clk_sys);
    statusWr = 1'b1;
    statusIn = 16'h0180;
    intTaken = 1'b1;
    @(negedge clk_sys);
    statusWr = 1'b0;
    intTaken = 1'b0;
    chkF(userMode, 1'b0);
    chkF(mapFileSel, 1'b0);
    $display("t_priv done");
  endtask
  task automatic t_reset;
    chkF(userMode, 1'b0);
    chkF(mapFileSel, 1'b0);
    chkF(physReq, 1'b0);
    chkF(mapFault, 1'b0);
    $display("t_reset done");
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    {srst, memReq, privOp, loadMapReq, statusWr, intTaken, xopTaken} = 7'h40;
    {logAddr, loadData, statusIn, loadFile, loadIdx} = 53'h0;
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    t_reset();
    t_map();
    t_file();
    t_priv();
    tally_and_finish();
  end
endmodule
